// ---- core/flash_port_pkg.sv ----
// Purpose: Shared constants for the code flash programming port and its programmer.
// Assumes: Both ends run from a 25 MHz ref_clk; the device oscillator is that clock.
// Notes: Cycle counts derive from printed times; long counts become top parameters.
`default_nettype none
package flash_port_pkg;
  localparam int CLK_NS = 40;
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int CNT_W = 24;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  // Serial opcodes, enable key and echo, and sub-commands in the second byte.
  localparam logic [7:0] OP_ENABLE = 8'hAC;
  localparam logic [7:0] EN_KEY = 8'h53;
  localparam logic [7:0] EN_ECHO = 8'h69;
  localparam logic [7:0] OP_RD_BYTE = 8'h20;
  localparam logic [7:0] OP_WR_BYTE = 8'h40;
  localparam logic [7:0] OP_RD_LOCK = 8'h24;
  localparam logic [7:0] OP_RD_SIG = 8'h28;
  localparam logic [7:0] OP_RD_PAGE = 8'h30;
  localparam logic [7:0] OP_WR_PAGE = 8'h50;
  localparam logic [2:0] SUB_ERASE = 3'h4;
  localparam logic [2:0] SUB_LOCK = 3'h7;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] ERASE_READ = 8'h00;
  localparam int LOCK_READ_LSB = 2;
  // Identification bytes: values are arbitrary.
  localparam logic [7:0] SIG0 = 8'h5A;
  localparam logic [7:0] SIG1 = 8'hA5;
  localparam logic [7:0] SIG2 = 8'h3C;
  // Times as printed, and the cycle counts taken from them.
  localparam int BYTE_WR_US = 1000;
  localparam int BYTE_WR_CYCLES = BYTE_WR_US * 1000 / CLK_NS;
  localparam int ERASE_MS = 500;
  localparam int ERASE_CYCLES = ERASE_MS * 1000 * 1000 / CLK_NS;
  localparam int PAR_WR_US = 50;
  localparam int PAR_WR_CYCLES = PAR_WR_US * 1000 / CLK_NS;
  localparam int BUSY_LAG_NS = 1000;
  localparam int BUSY_LAG_CYC = BUSY_LAG_NS / CLK_NS;
  localparam int READ_VALID_OSC = 48;
  localparam int READ_WAIT_CYC = READ_VALID_OSC + 4;
  localparam int PULSE_MIN_NS = 200;
  localparam int PULSE_MAX_NS = 500;
  localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPP_SETUP_US = 10;
  localparam int VPP_SETUP_CYC = (VPP_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_MS = 10;
  localparam int SETTLE_CYCLES = SETTLE_MS * 1000 * 1000 / CLK_NS;
  localparam int SCK_LOW_CLKS = 64;
  localparam int SCK_RATIO = 16;
  localparam int SCK_HALF_CYC = SCK_RATIO;
  // Parallel request word fields.
  localparam int PF_WRITE = 31;
  localparam int PF_MODE_LSB = 24;
  localparam int PF_ADDR_LSB = 8;
  typedef enum {
    POP_NONE, POP_WR_CODE, POP_RD_CODE, POP_LOCK1, POP_LOCK2, POP_LOCK3,
    POP_RD_LOCK, POP_ERASE, POP_RD_SIG
  } par_op_e;
  // Mode select order: {sel3, read_enable, sel2, sel1, sel0}.
  function automatic par_op_e decode_par(input logic [4:0] m);
    unique case (m)
      5'h0F: return POP_WR_CODE;
      5'h03: return POP_RD_CODE;
      5'h1F: return POP_LOCK1;
      5'h1C: return POP_LOCK2;
      5'h16: return POP_LOCK3;
      5'h1A: return POP_RD_LOCK;
      5'h14: return POP_ERASE;
      5'h00: return POP_RD_SIG;
      default: return POP_NONE;
    endcase
  endfunction : decode_par
endpackage : flash_port_pkg
`default_nettype wire

// ---- core/flash_port_if.sv ----
// Purpose: Pin bundle between the flash port and its external programmer.
// Assumes: The data bus floats high when neither end enables it.
// Notes: mode_sel is {sel3, sel2, sel1, sel0}; read_enable_pin sits apart.
`default_nettype none
interface flash_port_if;
  import flash_port_pkg::*;
  logic prog_rst;
  logic sck;
  logic mosi;
  logic miso;
  logic store_strobe_pin;
  logic program_voltage_pin;
  logic program_pulse_pin;
  logic read_enable_pin;
  logic [3:0] mode_sel;
  logic [3:0] addr_hi;
  logic [7:0] addr_lo;
  logic [7:0] dev_data_o;
  logic dev_data_oe;
  logic [7:0] host_data_o;
  logic host_data_oe;
  logic [7:0] data_bus;
  logic write_progress_output;

  assign data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : BUS_IDLE);

  modport device(
    input prog_rst, sck, mosi, store_strobe_pin, program_voltage_pin, program_pulse_pin,
    input read_enable_pin, mode_sel, addr_hi, addr_lo, data_bus,
    output miso, dev_data_o, dev_data_oe, write_progress_output
  );
  modport programmer(
    output prog_rst, sck, mosi, store_strobe_pin, program_voltage_pin, program_pulse_pin,
    output read_enable_pin, mode_sel, addr_hi, addr_lo, host_data_o, host_data_oe,
    input miso, data_bus, write_progress_output
  );
endinterface : flash_port_if
`default_nettype wire

// ---- core/flash_port_device.sv ----
// Purpose: Code flash array with its serial and parallel programming port.
// Assumes: ref_clk is the device oscillator; every pin is asynchronous to it.
// Notes: Low store_strobe_pin selects parallel mode, high selects serial mode.
`default_nettype none
module flash_port_device
  import flash_port_pkg::*;
#(
  parameter int BYTE_WR_CYC = BYTE_WR_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  flash_port_if.device pins,
  output logic normal_run
);
  localparam int SYNC_W = 31;

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic s_rst, s_sck, s_mosi, s_strobe, s_vpp, s_pulse, s_re;
  logic [3:0] s_sel;
  logic [ADDR_W-1:0] s_addr;
  logic [7:0] s_data;
  logic ser_mode, par_mode, sck_d_ff, pulse_low_ff, sck_rise, sck_fall;
  logic [6:0] rx_ff;
  logic [7:0] rx_byte, op_ff, b1_ff, b2_ff, page_cnt_ff, tx_ff, tx_next;
  logic [2:0] bit_ff;
  logic [1:0] idx_ff;
  logic page_ff, enabled_ff, byte_done, instr_done, is_enable, is_page, ser_ok;
  logic ser_wr, ser_erase, par_start, par_wr, erase_start, wr_en;
  logic [2:0] lock_ff, lock_set;
  logic [ADDR_W-1:0] ser_addr, wr_addr, rd_addr, last_addr_ff;
  logic [7:0] wr_data, rd_val, last_data_ff, lock_val, par_val;
  logic [CNT_W-1:0] erase_cnt_ff, busy_cnt_ff;
  logic erasing, busy, miso_ff, dout_oe_ff, progress_ff, normal_ff;
  logic [7:0] dout_ff;
  logic [7:0] mem [MEM_DEPTH];
  par_op_e pop;

  function automatic logic [7:0] sig_byte(input logic [3:0] hi);
    unique case (hi)
      4'h0: return SIG0;
      4'h1: return SIG1;
      4'h2: return SIG2;
      default: return '0;
    endcase
  endfunction : sig_byte

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; nothing but the second stage reads the first.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {pins.prog_rst, pins.sck, pins.mosi, pins.store_strobe_pin,
                  pins.program_voltage_pin, pins.program_pulse_pin, pins.read_enable_pin,
                  pins.mode_sel, pins.addr_hi, pins.addr_lo, pins.data_bus};
      sync_ff <= meta_ff;
    end
  end

  assign {s_rst, s_sck, s_mosi, s_strobe, s_vpp, s_pulse, s_re, s_sel, s_addr, s_data} = sync_ff;
  assign ser_mode = s_rst && s_strobe;
  assign par_mode = s_rst && !s_strobe;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sck_d_ff <= 1'b0;
      pulse_low_ff <= 1'b0;
      normal_ff <= 1'b0;
    end else begin
      sck_d_ff <= s_sck;
      pulse_low_ff <= par_mode && !s_pulse;
      normal_ff <= !s_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive and instruction framing.
  assign sck_rise = ser_mode && s_sck && !sck_d_ff;
  assign sck_fall = ser_mode && !s_sck && sck_d_ff;
  assign rx_byte = {rx_ff, s_mosi};
  assign byte_done = sck_rise && (&bit_ff);
  assign instr_done = byte_done && !page_ff && (&idx_ff);
  assign is_enable = (op_ff == OP_ENABLE) && (b1_ff == EN_KEY);
  assign is_page = (op_ff == OP_RD_PAGE) || (op_ff == OP_WR_PAGE);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_ff <= '0;
      bit_ff <= '0;
      idx_ff <= '0;
      page_ff <= 1'b0;
      page_cnt_ff <= '0;
      op_ff <= '0;
      b1_ff <= '0;
      b2_ff <= '0;
    end else if (!ser_mode) begin
      bit_ff <= '0;
      idx_ff <= '0;
      page_ff <= 1'b0;
    end else if (sck_rise) begin
      rx_ff <= rx_byte[6:0];
      bit_ff <= bit_ff + 3'h1;
      if (byte_done && page_ff) begin
        page_cnt_ff <= page_cnt_ff + 8'h01;
        if (page_cnt_ff == PAGE_LAST) begin
          page_ff <= 1'b0;
        end
      end else if (byte_done) begin
        idx_ff <= idx_ff + 2'h1;
        unique case (idx_ff)
          2'h0: op_ff <= rx_byte;
          2'h1: begin
            b1_ff <= rx_byte;
            if (enabled_ff && is_page) begin
              page_ff <= 1'b1;
              page_cnt_ff <= '0;
              idx_ff <= '0;
            end
          end
          2'h2: b2_ff <= rx_byte;
          2'h3: ;
        endcase
      end
    end
  end

  // Enable is lost whenever the reset pin falls, so each session starts locked out.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      enabled_ff <= 1'b0;
    end else if (!s_rst) begin
      enabled_ff <= 1'b0;
    end else if (instr_done && is_enable) begin
      enabled_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write, erase and lock requests from both modes.
  assign ser_ok = enabled_ff && !erasing;
  assign ser_addr = page_ff ? {b1_ff[3:0], page_cnt_ff} : {b1_ff[3:0], b2_ff};
  assign ser_wr = ser_ok && ((instr_done && op_ff == OP_WR_BYTE) ||
                             (byte_done && page_ff && op_ff == OP_WR_PAGE));
  assign ser_erase = ser_ok && instr_done && op_ff == OP_ENABLE && b1_ff[7:5] == SUB_ERASE;
  assign pop = decode_par({s_sel[3], s_re, s_sel[2:0]});
  assign par_start = pulse_low_ff && s_pulse && par_mode && s_vpp && !erasing && !busy;
  assign par_wr = par_start && pop == POP_WR_CODE;
  assign erase_start = ser_erase || (par_start && pop == POP_ERASE);
  assign wr_en = ser_wr || par_wr;
  assign wr_addr = par_mode ? s_addr : ser_addr;
  assign wr_data = par_mode ? s_data : rx_byte;

  always_comb begin
    lock_set = '0;
    if (ser_ok && instr_done && op_ff == OP_ENABLE && b1_ff[7:5] == SUB_LOCK) begin
      unique case (b1_ff[1:0])
        2'h0: lock_set = 3'h0;
        2'h1: lock_set = 3'h1;
        2'h2: lock_set = 3'h2;
        2'h3: lock_set = 3'h4;
      endcase
    end else if (par_start) begin
      lock_set = {pop == POP_LOCK3, pop == POP_LOCK2, pop == POP_LOCK1};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_ff <= '0;
    end else if (erase_start) begin
      lock_ff <= '0;
    end else begin
      lock_ff <= lock_ff | lock_set;
    end
  end

  // Erase runs its full time; the sweep writes on every count, covering the array once per 4096 counts.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      erase_cnt_ff <= '0;
    end else if (erase_start) begin
      erase_cnt_ff <= CNT_W'(ERASE_CYC);
    end else if (erasing) begin
      erase_cnt_ff <= erase_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_ff <= '0;
      last_addr_ff <= '0;
      last_data_ff <= '0;
    end else if (wr_en) begin
      busy_cnt_ff <= par_mode ? CNT_W'(PAR_WR_CYCLES) : CNT_W'(BYTE_WR_CYC);
      last_addr_ff <= wr_addr;
      last_data_ff <= wr_data;
    end else if (par_start && |lock_set) begin
      busy_cnt_ff <= CNT_W'(PAR_WR_CYCLES);
    end else if (busy) begin
      busy_cnt_ff <= busy_cnt_ff - 1'b1;
    end
  end

  assign erasing = |erase_cnt_ff;
  assign busy = |busy_cnt_ff;

  // Programming can only clear bits, so rewriting without an erase merges data.
  always_ff @(posedge ref_clk) begin
    if (erasing) begin
      mem[erase_cnt_ff[ADDR_W-1:0]] <= ERASED;
    end else if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] & wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path shared by both modes.
  assign rd_addr = par_mode ? s_addr : ser_addr;
  assign lock_val = 8'(lock_ff) << LOCK_READ_LSB;

  always_comb begin
    rd_val = mem[rd_addr];
    if (erasing) begin
      rd_val = ERASE_READ;
    end else if (busy && rd_addr == last_addr_ff) begin
      rd_val = {~last_data_ff[7], last_data_ff[6:0]};
    end
  end

  always_comb begin
    tx_next = '0;
    if (page_ff) begin
      if (enabled_ff && op_ff == OP_RD_PAGE) begin
        tx_next = rd_val;
      end
    end else if (&idx_ff) begin
      if (is_enable) begin
        tx_next = EN_ECHO;
      end else if (enabled_ff) begin
        unique case (op_ff)
          OP_RD_BYTE: tx_next = rd_val;
          OP_RD_LOCK: tx_next = lock_val;
          OP_RD_SIG: tx_next = sig_byte(b1_ff[3:0]);
          default: tx_next = '0;
        endcase
      end
    end
  end

  // A new byte is loaded on the first falling edge after a byte boundary.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      miso_ff <= 1'b0;
      tx_ff <= '0;
    end else if (!ser_mode) begin
      miso_ff <= 1'b0;
    end else if (sck_fall) begin
      if (bit_ff == 3'h0) begin
        miso_ff <= tx_next[7];
        tx_ff <= {tx_next[6:0], 1'b0};
      end else begin
        miso_ff <= tx_ff[7];
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  always_comb begin
    unique case (pop)
      POP_RD_CODE: par_val = rd_val;
      POP_RD_LOCK: par_val = lock_val;
      POP_RD_SIG: par_val = sig_byte(s_addr[ADDR_W-1:8]);
      default: par_val = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dout_ff <= '0;
      dout_oe_ff <= 1'b0;
      progress_ff <= 1'b1;
    end else begin
      dout_ff <= par_val;
      dout_oe_ff <= par_mode && (pop == POP_RD_CODE || pop == POP_RD_LOCK || pop == POP_RD_SIG);
      progress_ff <= !(par_mode && (busy || erasing));
    end
  end

  assign pins.miso = miso_ff;
  assign pins.dev_data_o = dout_ff;
  assign pins.dev_data_oe = dout_oe_ff;
  assign pins.write_progress_output = progress_ff;
  assign normal_run = normal_ff;
endmodule : flash_port_device
`default_nettype wire

// ---- core/flash_port_programmer.sv ----
// Purpose: External programmer end; runs serial and parallel transfers on request.
// Assumes: The device oscillator equals ref_clk, so shift clock of ref_clk/32 is legal.
// Notes: The user must send the enable instruction first and erase before rewriting.
`default_nettype none
module flash_port_programmer
  import flash_port_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  flash_port_if.programmer pins,
  input wire logic session,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_parallel,
  input wire logic [1:0] req_nbytes,
  input wire logic [31:0] req_word,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef enum {ST_OFF, ST_SETTLE, ST_IDLE, ST_SHIFT, ST_PSET, ST_PPULSE, ST_PBUSY, ST_PREAD}
    host_st_e;

  host_st_e st_ff;
  logic [9:0] meta_ff, sync_ff;
  logic s_miso, s_prog;
  logic [7:0] s_data;
  logic [CNT_W-1:0] cnt_ff;
  logic [31:0] sh_ff;
  logic [5:0] bits_ff;
  logic [7:0] rx_ff, dout_ff, rsp_data_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [3:0] sel_ff;
  logic rst_ff, sck_ff, mosi_ff, strobe_ff, vpp_ff, pulse_ff, re_ff, doe_ff, rsp_ff;
  logic cnt_zero;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {pins.miso, pins.write_progress_output, pins.data_bus};
      sync_ff <= meta_ff;
    end
  end

  assign {s_miso, s_prog, s_data} = sync_ff;
  assign cnt_zero = cnt_ff == '0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; every pin is driven from a flop.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= ST_OFF;
      cnt_ff <= '0;
      {rst_ff, sck_ff, mosi_ff, vpp_ff, re_ff, doe_ff, rsp_ff} <= '0;
      {strobe_ff, pulse_ff} <= 2'h3;
      {sh_ff, bits_ff, rx_ff, dout_ff, rsp_data_ff, addr_ff, sel_ff} <= '0;
    end else begin
      rsp_ff <= 1'b0;
      unique case (st_ff)
        ST_OFF: if (session) begin
          rst_ff <= 1'b1;
          cnt_ff <= CNT_W'(SETTLE_CYC);
          st_ff <= ST_SETTLE;
        end
        ST_SETTLE: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_zero) st_ff <= ST_IDLE;
        end
        ST_IDLE: if (!session) begin
          rst_ff <= 1'b0;
          st_ff <= ST_OFF;
        end else if (req_valid && !req_parallel) begin
          strobe_ff <= 1'b1;
          sh_ff <= req_word;
          mosi_ff <= req_word[31];
          // The byte count is widened first so that four bytes do not wrap to zero.
          bits_ff <= {({1'b0, req_nbytes} + 3'h1), 3'h0};
          cnt_ff <= CNT_W'(SCK_HALF_CYC);
          st_ff <= ST_SHIFT;
        end else if (req_valid) begin
          strobe_ff <= 1'b0;
          vpp_ff <= req_word[PF_WRITE];
          doe_ff <= req_word[PF_WRITE];
          {sel_ff[3], re_ff, sel_ff[2:0]} <= req_word[PF_MODE_LSB +: 5];
          addr_ff <= req_word[PF_ADDR_LSB +: ADDR_W];
          dout_ff <= req_word[7:0];
          cnt_ff <= req_word[PF_WRITE] ? CNT_W'(VPP_SETUP_CYC) : CNT_W'(READ_WAIT_CYC);
          st_ff <= req_word[PF_WRITE] ? ST_PSET : ST_PREAD;
        end
        ST_SHIFT: if (cnt_ff != CNT_W'(1)) begin
          cnt_ff <= cnt_ff - 1'b1;
        end else begin
          cnt_ff <= CNT_W'(SCK_HALF_CYC);
          sck_ff <= !sck_ff;
          if (!sck_ff) begin
            rx_ff <= {rx_ff[6:0], s_miso};
          end else begin
            sh_ff <= {sh_ff[30:0], 1'b0};
            mosi_ff <= sh_ff[30];
            bits_ff <= bits_ff - 6'h1;
            if (bits_ff == 6'h1) begin
              rsp_ff <= 1'b1;
              rsp_data_ff <= rx_ff;
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_PSET: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_zero) begin
            pulse_ff <= 1'b0;
            cnt_ff <= CNT_W'(PULSE_CYC - 1);
            st_ff <= ST_PPULSE;
          end
        end
        ST_PPULSE: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_zero) begin
            pulse_ff <= 1'b1;
            cnt_ff <= CNT_W'(BUSY_LAG_CYC);
            st_ff <= ST_PBUSY;
          end
        end
        ST_PBUSY: if (!cnt_zero) begin
          cnt_ff <= cnt_ff - 1'b1;
        end else if (s_prog) begin
          vpp_ff <= 1'b0;
          doe_ff <= 1'b0;
          rsp_ff <= 1'b1;
          st_ff <= ST_IDLE;
        end
        ST_PREAD: begin
          cnt_ff <= cnt_ff - 1'b1;
          if (cnt_zero) begin
            rsp_ff <= 1'b1;
            rsp_data_ff <= s_data;
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign req_ready = st_ff == ST_IDLE && session;
  assign rsp_valid = rsp_ff;
  assign rsp_data = rsp_data_ff;
  assign pins.prog_rst = rst_ff;
  assign pins.sck = sck_ff;
  assign pins.mosi = mosi_ff;
  assign pins.store_strobe_pin = strobe_ff;
  assign pins.program_voltage_pin = vpp_ff;
  assign pins.program_pulse_pin = pulse_ff;
  assign pins.read_enable_pin = re_ff;
  assign pins.mode_sel = sel_ff;
  assign pins.addr_hi = addr_ff[ADDR_W-1:8];
  assign pins.addr_lo = addr_ff[7:0];
  assign pins.host_data_o = dout_ff;
  assign pins.host_data_oe = doe_ff;
endmodule : flash_port_programmer
`default_nettype wire

// ---- test/flash_port_monitor.sv ----
// Purpose: Checker on the pins between the flash port and its programmer.
// Assumes: All pins are sampled on ref_clk.
// Notes: The busy limit follows the op that started it.
`default_nettype none
module flash_port_monitor
  import flash_port_pkg::*;
#(parameter int ERASE_CYC = 4200) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic prog_rst,
  input wire logic sck,
  input wire logic miso,
  input wire logic store_strobe_pin,
  input wire logic program_voltage_pin,
  input wire logic program_pulse_pin,
  input wire logic read_enable_pin,
  input wire logic [3:0] mode_sel,
  input wire logic dev_data_oe,
  input wire logic write_progress_output
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] busy_cnt_ff;
  logic erase_ff;
  ////////////////////////////////////////////////////////////////
  // Erase shares the busy pin but runs far longer, so the mode is kept.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) busy_cnt_ff <= '0;
    else busy_cnt_ff <= write_progress_output ? '0 : busy_cnt_ff + 16'h1;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) erase_ff <= 1'b0;
    else if (write_progress_output) erase_ff <= mode_sel == 4'hC && !read_enable_pin;
  end
  reset_quiet_a: assert property (!prog_rst [*4] |-> !miso && !dev_data_oe)
    else $error("outputs active outside session");
  parallel_quiet_a: assert property (!store_strobe_pin [*4] |-> !miso)
    else $error("serial output active in parallel mode");
  serial_quiet_a: assert property (store_strobe_pin [*4] |-> !dev_data_oe)
    else $error("data bus driven in serial mode");
  miso_edge_a: assert property ($changed(miso) |-> !sck)
    else $error("serial output moved while shift clock high");
  busy_lag_a: assert property ($rose(program_pulse_pin) && !store_strobe_pin &&
    program_voltage_pin && write_progress_output |-> ##[1:25] !write_progress_output)
    else $error("busy late after pulse");
  busy_cause_a: assert property ($fell(write_progress_output) |->
    program_pulse_pin && !store_strobe_pin && program_voltage_pin)
    else $error("busy without a pulse");
  write_time_a: assert property (busy_cnt_ff <= (erase_ff ? ERASE_CYC : PAR_WR_CYCLES))
    else $error("write cycle too long");
  read_valid_a: assert property ((!store_strobe_pin && !read_enable_pin &&
    mode_sel == 4'h3) [*8] |-> dev_data_oe)
    else $error("read data not driven");
  cover property ($fell(write_progress_output));
  cover property ($rose(miso));
  cover property ($rose(dev_data_oe));
endmodule : flash_port_monitor
`default_nettype wire

// ---- test/code_flash_programming_port_bench.sv ----
// Purpose: Programmer and flash port joined by pins, checked against a memory model.
// Assumes: Short parameters stand in for long erase, write and settle times.
// Notes: Write cycle is kept long so a polling read lands inside it.
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp); end end
module code_flash_programming_port_bench import flash_port_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WR_CYC = 3000;
  localparam int ER_CYC = 4200;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic session = 1'b0;
  logic req_valid = 1'b0;
  logic req_parallel = 1'b0;
  logic [31:0] req_word = '0;
  logic req_ready, rsp_valid, normal_run;
  logic [7:0] rsp_data, got, d;
  logic [11:0] a;
  logic [7:0] mem [int];
  logic [7:0] sig [3] = '{SIG0, SIG1, SIG2};
  logic [4:0] lk [3] = '{5'h1F, 5'h1C, 5'h16};
  int num_errors = 0;
  int check_count = 0;
  always #20 ref_clk = ~ref_clk;
  flash_port_if pins();
  flash_port_device #(.BYTE_WR_CYC(WR_CYC), .ERASE_CYC(ER_CYC)) u_flash_port_device (
    .ref_clk(ref_clk), .nrst(nrst), .pins(pins), .normal_run(normal_run));
  flash_port_programmer #(.SETTLE_CYC(100)) u_flash_port_programmer (.ref_clk(ref_clk),
    .nrst(nrst), .pins(pins), .session(session), .req_valid(req_valid),
    .req_ready(req_ready), .req_parallel(req_parallel), .req_nbytes(2'h3),
    .req_word(req_word), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  flash_port_monitor #(.ERASE_CYC(ER_CYC)) u_flash_port_monitor (.ref_clk(ref_clk),
    .nrst(nrst), .prog_rst(pins.prog_rst), .sck(pins.sck), .miso(pins.miso),
    .store_strobe_pin(pins.store_strobe_pin), .program_voltage_pin(pins.program_voltage_pin),
    .program_pulse_pin(pins.program_pulse_pin), .read_enable_pin(pins.read_enable_pin),
    .mode_sel(pins.mode_sel), .dev_data_oe(pins.dev_data_oe),
    .write_progress_output(pins.write_progress_output));
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic tick(inout int n);
    @(posedge ref_clk) #1;
    n++;
    if (n > 9000) begin
      num_errors++;
      $display("CHECK FAILED t=%0t timeout", $time);
      report_and_stop();
    end
  endtask : tick
  // Request is held until the edge that takes it, then the pulse answer is awaited.
  task automatic xfer(input logic par, input logic [31:0] w, output logic [7:0] r);
    int n;
    n = 0;
    tick(n);
    while (req_ready !== 1'b1) tick(n);
    req_parallel = par;
    req_word = w;
    req_valid = 1'b1;
    tick(n);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1) tick(n);
    r = rsp_data;
  endtask : xfer
  initial begin
    void'($urandom(32'h50AC5CFC));
    repeat (10) @(posedge ref_clk);
    #1 nrst = 1'b1;
    session = 1'b1;
    xfer(0, {OP_ENABLE, EN_KEY, 16'h0}, got); `CHK(got, EN_ECHO)
    `CHK(normal_run, 1'b0)
    xfer(0, 32'hAC800000, got);
    xfer(0, 32'h20012300, got); `CHK(got, ERASE_READ)
    repeat (ER_CYC) @(posedge ref_clk);
    xfer(0, 32'h20012300, got); `CHK(got, ERASED)
    for (int i = 0; i < 4; i++) begin
      a = {i[1:0], 10'($urandom)};
      d = 8'($urandom);
      mem[a] = d;
      xfer(0, {OP_WR_BYTE, 4'h0, a, d}, got);
    end
    xfer(0, {OP_RD_BYTE, 4'h0, a, 8'h00}, got); `CHK(got, d ^ 8'h80)
    repeat (WR_CYC) @(posedge ref_clk);
    foreach (mem[k]) begin
      xfer(0, {OP_RD_BYTE, 4'h0, 12'(k), 8'h00}, got); `CHK(got, mem[k])
    end
    for (int s = 0; s < 3; s++) begin
      xfer(0, {OP_RD_SIG, 4'h0, 4'(s), 16'h0}, got); `CHK(got, sig[s])
    end
    $display("serial test done");
    session = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    `CHK(normal_run, 1'b1)
    session = 1'b1;
    xfer(0, 32'hAC800000, got);
    xfer(0, {OP_ENABLE, EN_KEY, 16'h0}, got);
    xfer(0, {OP_RD_BYTE, 4'h0, a, 8'h00}, got); `CHK(got, mem[a])
    $display("enable test done");
    xfer(1, {8'h94, 24'h0}, got);
    a = 12'($urandom);
    d = 8'($urandom);
    xfer(1, {8'h8F, 4'h0, a, d}, got);
    xfer(1, {8'h03, 4'h0, a, 8'h00}, got); `CHK(got, d)
    xfer(1, {8'h03, 4'h0, a ^ 12'h800, 8'h00}, got); `CHK(got, ERASED)
    foreach (lk[i]) xfer(1, {3'b100, lk[i], 24'h0}, got);
    xfer(1, {8'h1A, 24'h0}, got); `CHK(got & 8'h1C, 8'h1C)
    for (int s = 0; s < 3; s++) begin
      xfer(1, {12'h0, 4'(s), 16'h0}, got); `CHK(got, sig[s])
    end
    $display("parallel test done");
    report_and_stop();
  end
endmodule : code_flash_programming_port_bench
`default_nettype wire
